// file: logic/sleep_ctl_pkg.sv
package sleep_ctl_pkg;

	// Sleep mode codes as software selects them
	typedef enum logic [2:0] {
		MODE_IDLE = 3'h0,
		MODE_NOISE_RED = 3'h1,
		MODE_PWR_DOWN = 3'h2,
		MODE_PWR_SAVE = 3'h3,
		MODE_STANDBY = 3'h6,
		MODE_EXT_STANDBY = 3'h7
	} sleep_mode_t;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'h0,
		ST_ENTER = 2'h1,
		ST_SLEEP = 2'h2,
		ST_WAKE = 2'h3
	} sleep_state_t;

	// Clock and unit run enables, one bit per domain
	typedef struct packed {
		logic cpu;
		logic sram;
		logic io;
		logic intr;
		logic adc;
		logic async_tmr;
		logic osc;
	} clk_en_t;

	localparam clk_en_t CLK_EN_ALL = 7'h7f;
	localparam clk_en_t CLK_EN_RESET = 7'h7f;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam int WAKE_SETTLE_CYCLES = 2;

endpackage : sleep_ctl_pkg

// file: logic/sleep_enable_map.sv
module sleep_enable_map
	import sleep_ctl_pkg::*;
(
	input wire logic [2:0] mode,
	output clk_en_t en
);

	always_comb begin
		en = '0;
		unique case (mode)
			MODE_IDLE: begin
				en = CLK_EN_ALL;
				en.cpu = 1'b0;
			end
			MODE_NOISE_RED: begin
				en.osc = 1'b1;
				en.sram = 1'b1;
				en.intr = 1'b1;
				en.adc = 1'b1;
				en.async_tmr = 1'b1;
			end
			MODE_PWR_DOWN: begin
				en = '0;
			end
			MODE_PWR_SAVE: begin
				en.async_tmr = 1'b1;
			end
			MODE_STANDBY: begin
				en.osc = 1'b1;
			end
			MODE_EXT_STANDBY: begin
				en.osc = 1'b1;
				en.async_tmr = 1'b1;
			end
			default: begin
				en = CLK_EN_ALL;
				en.cpu = 1'b0;
			end
		endcase
	end

endmodule : sleep_enable_map

// file: logic/sleep_ctl.sv
module sleep_ctl
	import sleep_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sleep_req,
	input wire logic [2:0] sleep_mode_sel,
	input wire logic wake_irq,
	output clk_en_t clk_en_ff,
	output logic sleeping_ff,
	output logic mode_err_ff,
	output logic [2:0] active_mode_ff
);

	sleep_state_t state_ff;
	sleep_state_t nxt_state;
	clk_en_t nxt_clk_en;
	clk_en_t mode_en;
	logic nxt_sleeping;
	logic nxt_mode_err;
	logic [2:0] nxt_active_mode;
	logic [1:0] wait_ff;
	logic [1:0] nxt_wait;
	logic irq_sync1_ff;
	logic irq_sync2_ff;

	// Mode code 4 and 5 are unassigned
	function automatic logic mode_legal(input logic [2:0] m);
		mode_legal = (m == MODE_IDLE) || (m == MODE_NOISE_RED) || (m == MODE_PWR_DOWN) ||
			(m == MODE_PWR_SAVE) || (m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
	endfunction : mode_legal

	sleep_enable_map u_map (
		.mode(active_mode_ff),
		.en(mode_en)
	);

	// Wake line may come from an asynchronous source
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			irq_sync1_ff <= 1'b0;
			irq_sync2_ff <= 1'b0;
		end else begin
			irq_sync1_ff <= wake_irq;
			irq_sync2_ff <= irq_sync1_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_clk_en = clk_en_ff;
		nxt_sleeping = sleeping_ff;
		nxt_mode_err = mode_err_ff;
		nxt_active_mode = active_mode_ff;
		nxt_wait = wait_ff;
		unique case (state_ff)
			ST_ACTIVE: begin
				nxt_clk_en = CLK_EN_ALL;
				if (sleep_req) begin
					if (mode_legal(sleep_mode_sel)) begin
						nxt_active_mode = sleep_mode_sel;
						nxt_mode_err = 1'b0;
						nxt_state = ST_ENTER;
					end else begin
						nxt_mode_err = 1'b1;
					end
				end
			end
			ST_ENTER: begin
				nxt_clk_en = mode_en;
				nxt_sleeping = 1'b1;
				nxt_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (irq_sync2_ff) begin
					nxt_clk_en.osc = 1'b1;
					nxt_wait = WAKE_SETTLE_CYCLES[1:0];
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wait_ff == 2'h0) begin
					nxt_clk_en = CLK_EN_ALL;
					nxt_sleeping = 1'b0;
					nxt_state = ST_ACTIVE;
				end else begin
					nxt_wait = wait_ff - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff <= ST_ACTIVE;
			clk_en_ff <= CLK_EN_RESET;
			sleeping_ff <= 1'b0;
			mode_err_ff <= 1'b0;
			active_mode_ff <= MODE_RESET;
			wait_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			clk_en_ff <= nxt_clk_en;
			sleeping_ff <= nxt_sleeping;
			mode_err_ff <= nxt_mode_err;
			active_mode_ff <= nxt_active_mode;
			wait_ff <= nxt_wait;
		end
	end

endmodule : sleep_ctl

// file: verif/sleep_ctl_chk.sv
module sleep_ctl_chk
	import sleep_ctl_pkg::*;
(
	input logic clk_sys,
	input logic reset_n,
	input logic wake_irq,
	input clk_en_t clk_en_ff,
	input logic sleeping_ff,
	input logic [2:0] active_mode_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Enables seen on entry to a mode
	property p(m, e);
		$rose(sleeping_ff) && active_mode_ff == m |-> clk_en_ff == e;
	endproperty
	AST_IDLE: assert property (p(3'h0, 7'h3f)) else $error("m");
	AST_NOISE: assert property (p(3'h1, 7'h2f)) else $error("m");
	AST_DOWN: assert property (p(3'h2, 7'h00)) else $error("m");
	AST_SAVE: assert property (p(3'h3, 7'h02)) else $error("m");
	AST_STBY: assert property (p(3'h6, 7'h01)) else $error("m");
	AST_XSTBY: assert property (p(3'h7, 7'h03)) else $error("m");
	AST_WAKE: assert property (sleeping_ff && wake_irq |-> ##[1:12] !sleeping_ff) else $error("w");
	AST_RESUME: assert property ($fell(sleeping_ff) |-> clk_en_ff == 7'h7f) else $error("r");
	cover property ($rose(sleeping_ff));
	cover property ($fell(sleeping_ff));
	cover property ($rose(sleeping_ff) && active_mode_ff == 3'h2);
endmodule : sleep_ctl_chk

// file: verif/sleep_mode_clock_gating_bench.sv
module sleep_mode_clock_gating_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sleep_ctl_pkg::*;
	logic clk_sys = 0, reset_n = 0, sleep_req = 0, wake_irq = 0;
	logic [2:0] sleep_mode_sel = 3'h0, active_mode_ff;
	clk_en_t clk_en_ff;
	logic sleeping_ff, mode_err_ff;
	int errors = 0, check_count = 0, cyc = 0;
	sleep_ctl dut(.*);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cyc == 400) begin
		errors++;
		report_and_stop;
	end
	task chk(string n, logic [8:0] e, g);
		check_count++;
		if (e !== g) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task nap(int n);
		repeat (n) @(negedge clk_sys);
	endtask : nap
	// Request a mode, check entry, then wake and check full resume
	task go(logic [2:0] m, logic [8:0] e, logic [2:0] am);
		sleep_mode_sel = m;
		sleep_req = 1;
		nap(1);
		sleep_req = 0;
		nap(2);
		chk("entry", e, {mode_err_ff, sleeping_ff, clk_en_ff});
		chk("mode", {6'h0, am}, {6'h0, active_mode_ff});
		wake_irq = 1;
		nap(1);
		wake_irq = 0;
		nap(2);
		chk("wake osc", {7'h0, e[7], 1'b1}, {7'h0, sleeping_ff, clk_en_ff.osc});
		nap(6);
		chk("exit", 9'h07f, {1'b0, sleeping_ff, clk_en_ff});
	endtask : go
	task report_and_stop;
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		nap(6);
		reset_n = 1;
		go(3'h5, 9'h17f, 3'h0);
		go(3'h0, 9'h0bf, 3'h0);
		go(3'h1, 9'h0af, 3'h1);
		go(3'h2, 9'h080, 3'h2);
		go(3'h3, 9'h082, 3'h3);
		go(3'h6, 9'h081, 3'h6);
		go(3'h7, 9'h083, 3'h7);
		report_and_stop;
	end
endmodule : sleep_mode_clock_gating_bench
bind sleep_ctl sleep_ctl_chk chk_i(.*);
